// File: rtl/cms_pkg.sv
// Constants and types for the controller operating mode sequencer
package cms_pkg;
    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // Register offsets
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_FAULT = 4'h2;
    // Control fields (write only, one-shot)
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int CTRL_OVR_BIT = 2;
    // Status fields
    localparam int ST_MODE_LSB = 0;
    localparam int ST_SEL_BIT = 3;
    localparam int ST_BATT_BIT = 4;
    localparam int ST_EMPTY_BIT = 5;
    localparam int ST_HOLD_BIT = 6;
    // Fault register field
    localparam int FLT_BIT = 0;
    // Reset value of read data
    localparam logic [7:0] RDATA_RST = 8'h00;
    // Timing
    localparam int CLK_HZ = 25000000;
    localparam int BATT_FLASH_MS = 100;
    localparam int BATT_FLASH_CYC = (CLK_HZ / 1000) * BATT_FLASH_MS;
    // Sequencer states
    typedef enum logic [2:0] {
        S_OFF,
        S_OVR,
        S_STOP,
        S_PARAM,
        S_ROUTINE,
        S_RUN
    } cms_state_t;
endpackage

// File: rtl/cms_top.sv
// Operating mode sequencer: switches, programmer requests, mode gating
`timescale 1ns/100ps
module cms_top #(
    parameter int BATT_FLASH_CYC = cms_pkg::BATT_FLASH_CYC
)(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Operator pins (asynchronous)
    input wire logic i_pwr_on,
    input wire logic i_sel_run,
    input wire logic i_batt_present,
    input wire logic i_act_supply,
    input wire logic i_malfunction,
    // Program executor handshakes (same clock)
    input wire logic i_param_done,
    input wire logic i_routine_done,
    input wire logic i_prog_loaded,
    // Register port
    input wire logic [cms_pkg::ADDR_W-1:0] i_addr,
    input wire logic [cms_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [cms_pkg::DATA_W-1:0] o_rdata,
    // Execution gating
    output logic o_prog_exec,
    output logic o_retain_hold,
    output logic o_timer_run,
    output logic o_counter_en,
    output logic o_scan_mon_en,
    output logic o_timed_irq_en,
    // I/O gating
    output logic o_onboard_out_en,
    output logic o_ext_io_en,
    output logic o_periph_ops_en,
    // Restart sequence
    output logic o_param_eval,
    output logic o_routine_run,
    output logic o_routine_sel,
    // Clearing
    output logic o_clear_pulse,
    output logic o_overall_clear,
    // Lamps
    output logic o_led_red,
    output logic o_led_green,
    output logic o_led_batt,
    output logic o_mod_fault_led
);
    import cms_pkg::*;

    localparam int FW = $clog2(BATT_FLASH_CYC + 1);

    ////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers

    logic rst_meta_reg; // First reset stage
    logic rst_n_reg; // Reset seen by the design
    logic [4:0] pin_meta_reg; // First stage, read by second only
    logic [4:0] pin_sync_reg; // Safe copies of the pins
    logic pwr_s;
    logic sel_s;
    logic batt_s;
    logic act_s;
    logic flt_s;

    // Release reset through two flops
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // Two flops on every operator pin
    always_ff @(posedge i_clk_sys or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
        end
        else
        begin
            pin_meta_reg <= {i_pwr_on, i_sel_run, i_batt_present,
                             i_act_supply, i_malfunction};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign {pwr_s, sel_s, batt_s, act_s, flt_s} = pin_sync_reg;

    ////////////////////////////////////////////////////////////////////
    // Selector qualification

    // Synchroniser must fill before the selector is trusted
    logic [1:0] sel_wait_reg;
    logic sel_valid_reg;

    always_ff @(posedge i_clk_sys or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            sel_wait_reg <= 2'h0;
            sel_valid_reg <= 1'b0;
        end
        else if (!sel_valid_reg)
        begin
            sel_wait_reg <= sel_wait_reg + 2'h1;
            sel_valid_reg <= (sel_wait_reg == 2'h3);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register port decode

    logic wr_ctrl;
    logic wr_fault;
    logic pg_run_req;
    logic pg_stop_req;
    logic pg_ovr_req;

    assign wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
    assign wr_fault = i_wr && (i_addr == ADDR_FAULT);
    // Programmer run and stop requests count only with selector at run
    assign pg_run_req = wr_ctrl && i_wdata[CTRL_RUN_BIT] && sel_s;
    assign pg_stop_req = wr_ctrl && i_wdata[CTRL_STOP_BIT] && sel_s;
    assign pg_ovr_req = wr_ctrl && i_wdata[CTRL_OVR_BIT];

    ////////////////////////////////////////////////////////////////////
    // Stop hold and fault flag

    logic hold_reg; // Keeps the block in stop despite selector at run
    logic fault_reg; // Sticky malfunction flag

    // Malfunction or programmer stop holds; selector to stop releases
    always_ff @(posedge i_clk_sys or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            hold_reg <= 1'b0;
        else if (flt_s || pg_stop_req)
            hold_reg <= 1'b1;
        else if (!sel_s || pg_run_req)
            hold_reg <= 1'b0;
    end

    // Set beats a clear in the same cycle
    always_ff @(posedge i_clk_sys or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            fault_reg <= 1'b0;
        else if (flt_s)
            fault_reg <= 1'b1;
        else if (wr_fault && i_wdata[FLT_BIT])
            fault_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Mode state machine

    cms_state_t state_reg;
    cms_state_t state_next;
    logic go_ok; // Conditions that allow leaving stop
    logic stop_cond; // Conditions that force stop

    assign go_ok = sel_valid_reg && sel_s && !hold_reg && !flt_s;
    assign stop_cond = !sel_s || hold_reg || flt_s || pg_stop_req;

    // Next mode
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            S_OFF:
            begin
                // Switch at 1 powers up; no battery forces overall reset
                if (pwr_s)
                    state_next = batt_s ? S_STOP : S_OVR;
            end
            S_OVR:
                state_next = S_STOP;
            S_STOP:
            begin
                if (!pwr_s)
                    state_next = S_OFF;
                else if (pg_ovr_req)
                    state_next = S_OVR;
                // Empty memory does not block the start
                else if (go_ok)
                    state_next = S_PARAM;
            end
            S_PARAM:
            begin
                if (!pwr_s)
                    state_next = S_OFF;
                else if (stop_cond)
                    state_next = S_STOP;
                else if (i_param_done)
                    state_next = S_ROUTINE;
            end
            S_ROUTINE:
            begin
                if (!pwr_s)
                    state_next = S_OFF;
                else if (stop_cond)
                    state_next = S_STOP;
                else if (i_routine_done)
                    state_next = S_RUN;
            end
            S_RUN:
            begin
                if (!pwr_s)
                    state_next = S_OFF;
                else if (stop_cond)
                    state_next = S_STOP;
            end
        endcase
    end

    // Power-on reset lands in off, then stop
    always_ff @(posedge i_clk_sys or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            state_reg <= S_OFF;
        else
            state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////
    // Restart routine choice and memory status

    logic pwr_restart_reg; // Restart follows a power-up
    logic mem_empty_reg; // Program memory erased

    // First restart after power-up uses the power restore routine
    always_ff @(posedge i_clk_sys or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            pwr_restart_reg <= 1'b0;
        else if (state_reg == S_OFF)
            pwr_restart_reg <= 1'b1;
        else if (state_reg == S_ROUTINE && i_routine_done)
            pwr_restart_reg <= 1'b0;
    end

    // Overall reset empties memory; a load fills it
    always_ff @(posedge i_clk_sys or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            mem_empty_reg <= 1'b1;
        else if (state_reg == S_OVR)
            mem_empty_reg <= 1'b1;
        else if (i_prog_loaded)
            mem_empty_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Gating outputs, registered from the next mode

    // Outputs line up with state_reg at the cost of wider decode
    always_ff @(posedge i_clk_sys or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            o_prog_exec <= 1'b0;
            o_retain_hold <= 1'b1;
            o_timer_run <= 1'b0;
            o_counter_en <= 1'b0;
            o_scan_mon_en <= 1'b0;
            o_timed_irq_en <= 1'b0;
            o_onboard_out_en <= 1'b0;
            o_ext_io_en <= 1'b0;
            o_periph_ops_en <= 1'b0;
            o_param_eval <= 1'b0;
            o_routine_run <= 1'b0;
            o_routine_sel <= 1'b0;
        end
        else
        begin
            o_prog_exec <= (state_next == S_RUN);
            // Values frozen in off and stop
            o_retain_hold <= (state_next inside {S_OFF, S_STOP});
            o_timer_run <= (state_next == S_RUN);
            o_counter_en <= (state_next == S_RUN);
            o_scan_mon_en <= (state_next == S_RUN);
            o_timed_irq_en <= (state_next == S_RUN);
            // Onboard outputs live in run and restart, zero in stop
            o_onboard_out_en <= (state_next inside
                {S_PARAM, S_ROUTINE, S_RUN});
            o_ext_io_en <= (state_next == S_RUN);
            o_periph_ops_en <= (state_next inside
                {S_PARAM, S_ROUTINE});
            o_param_eval <= (state_next == S_PARAM);
            o_routine_run <= (state_next == S_ROUTINE);
            o_routine_sel <= pwr_restart_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clearing pulses

    // Single-cycle strobes to the data store
    always_ff @(posedge i_clk_sys or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            o_clear_pulse <= 1'b0;
            o_overall_clear <= 1'b0;
        end
        else
        begin
            // Stop to restart edge wipes non-retentive data
            o_clear_pulse <= (state_reg == S_STOP)
                && (state_next == S_PARAM);
            o_overall_clear <= (state_next == S_OVR);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Lamps

    logic [FW-1:0] flash_cnt_reg; // Battery lamp power-on flash
    logic powered;

    assign powered = (state_next != S_OFF);

    // Flash window restarts on every power-up
    always_ff @(posedge i_clk_sys or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            flash_cnt_reg <= '0;
        else if (state_reg == S_OFF)
            flash_cnt_reg <= FW'(BATT_FLASH_CYC);
        else if (flash_cnt_reg != '0)
            flash_cnt_reg <= flash_cnt_reg - 1'b1;
    end

    // Lamps follow the next mode so they match the gating
    always_ff @(posedge i_clk_sys or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            o_led_red <= 1'b0;
            o_led_green <= 1'b0;
            o_led_batt <= 1'b0;
            o_mod_fault_led <= 1'b0;
        end
        else
        begin
            o_led_red <= powered && (state_next != S_RUN);
            o_led_green <= (state_next == S_RUN);
            o_led_batt <= powered && (!batt_s
                || (flash_cnt_reg != '0));
            o_mod_fault_led <= powered && ((state_next != S_RUN)
                || (!act_s && state_next != S_RUN));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read

    // Data stand only in the cycle after the strobe
    always_ff @(posedge i_clk_sys or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            o_rdata <= RDATA_RST;
        else if (!i_rd)
            o_rdata <= RDATA_RST;
        else if (i_addr == ADDR_STATUS)
        begin
            o_rdata <= RDATA_RST;
            o_rdata[ST_MODE_LSB +: 3] <= state_reg;
            o_rdata[ST_SEL_BIT] <= sel_s;
            o_rdata[ST_BATT_BIT] <= batt_s;
            o_rdata[ST_EMPTY_BIT] <= mem_empty_reg;
            o_rdata[ST_HOLD_BIT] <= hold_reg;
        end
        else if (i_addr == ADDR_FAULT)
            o_rdata <= {7'h00, fault_reg};
        else
            o_rdata <= RDATA_RST; // Control and unmapped read zero
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_n_reg);

    sequence stop_left_s;
        state_reg == S_STOP ##1 state_reg != S_STOP;
    endsequence

    sequence restart_entry_s;
        state_reg == S_STOP ##1 state_reg == S_PARAM;
    endsequence

    stop_exit_a: assert property (
        stop_left_s |-> state_reg inside {S_PARAM, S_OVR, S_OFF})
        else $error("stop left without restart");

    run_entry_a: assert property (
        $rose(state_reg == S_RUN) |-> $past(state_reg) == S_ROUTINE)
        else $error("run entered not from restart routine");

    stop_gate_a: assert property (
        state_reg == S_STOP |-> !o_onboard_out_en && !o_ext_io_en
            && !o_prog_exec && o_retain_hold)
        else $error("outputs live in stop");

    stop_count_a: assert property (
        state_reg == S_STOP |-> !o_counter_en)
        else $error("counters active in stop");

    clear_start_a: assert property (
        restart_entry_s |-> o_clear_pulse ##1 !o_clear_pulse)
        else $error("no clear on start");

    run_io_a: assert property (
        state_reg == S_RUN |-> o_prog_exec && o_ext_io_en && o_timer_run)
        else $error("run without full processing");

    restart_mon_a: assert property (
        state_reg inside {S_PARAM, S_ROUTINE} |-> !o_scan_mon_en
            && !o_timed_irq_en)
        else $error("monitor or timed work in restart");

    restart_io_a: assert property (
        state_reg inside {S_PARAM, S_ROUTINE} |-> o_onboard_out_en
            && o_periph_ops_en && !o_ext_io_en)
        else $error("wrong I/O gating in restart");

    prog_gate_a: assert property (
        state_reg == S_STOP && !sel_s |=> state_reg != S_PARAM)
        else $error("start with selector at stop");

    overall_clr_a: assert property (
        state_reg == S_OVR |-> o_overall_clear ##1 mem_empty_reg)
        else $error("overall reset incomplete");

    mode_lamp_a: assert property (
        (o_led_green == (state_reg == S_RUN))
            && (state_reg != S_STOP || o_led_red))
        else $error("mode lamp wrong");

    batt_lamp_a: assert property (
        !batt_s && state_next != S_OFF |=> o_led_batt)
        else $error("battery lamp dark without battery");

    power_off_a: assert property (
        !pwr_s && state_reg != S_OVR |=> state_reg == S_OFF)
        else $error("not shut down at switch 0");

    fault_lamp_a: assert property (
        !o_ext_io_en && state_reg != S_OFF |-> o_mod_fault_led)
        else $error("fault lamp dark with outputs off");

    sel_wait_a: assert property (
        !sel_valid_reg |=> state_reg != S_PARAM)
        else $error("moved before selector sampled");

endmodule

// File: dv/cms_far.sv
// Operator switches and program executor model facing the mode sequencer
`timescale 1ns/100ps
module cms_far #(
    parameter int OFF_CYC = 40
)(
    // Clock
    input wire logic i_clk,
    // Restart steps shown by the sequencer
    input wire logic i_param_eval,
    input wire logic i_routine_run,
    // Operator pins
    output logic o_pwr_on,
    output logic o_sel_run,
    output logic o_batt,
    output logic o_act,
    output logic o_malf,
    // Executor answers
    output logic o_param_done,
    output logic o_routine_done
);
    int lat = 12; // Answer delay in cycles, set by the bench
    int cnt = 0; // Cycles waited in the present step
    // Powered, stopped, battery in, supplies on
    initial
    begin
        {o_pwr_on, o_sel_run, o_batt, o_act, o_malf} = 5'h16;
        o_param_done = 1'b0;
        o_routine_done = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Switch group order: power, selector, battery, supply, fault
    task automatic drive(input logic [4:0] v);
        @(posedge i_clk);
        {o_pwr_on, o_sel_run, o_batt, o_act, o_malf} <= v;
    endtask
    // Overall reset by hand; the off time is shortened to keep runs brief
    task automatic clear_by_hand();
        drive(5'h12);
        drive(5'h02);
        repeat (OFF_CYC) @(posedge i_clk);
        drive(5'h12);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Each restart step gets exactly one done pulse, after lat cycles
    always @(posedge i_clk)
    begin
        o_param_done <= 1'b0;
        o_routine_done <= 1'b0;
        // Waiting for a step, and not the cycle right after a pulse
        if ((i_param_eval || i_routine_run) && !(o_param_done || o_routine_done))
        begin
            if (cnt >= lat)
            begin
                o_param_done <= i_param_eval;
                o_routine_done <= i_routine_run;
                cnt <= 0;
            end
            else
                cnt <= cnt + 1;
        end
        else
            cnt <= 0;
    end
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the operating mode sequencer
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    import cms_pkg::*;
    // Clock, reset and bench-driven inputs
    logic i_clk_sys = 1'b0;
    logic i_rstn;
    logic i_prog_loaded;
    logic [3:0] i_addr;
    logic [7:0] i_wdata;
    logic i_wr;
    logic i_rd;
    // Model-driven inputs
    logic pwr, sel, batt, act, malf, pdone, rdone;
    // Outputs
    logic [7:0] o_rdata;
    logic o_prog_exec, o_retain_hold, o_timer_run, o_counter_en, o_scan_mon_en;
    logic o_timed_irq_en, o_onboard_out_en, o_ext_io_en, o_periph_ops_en;
    logic o_param_eval, o_routine_run, o_routine_sel, o_clear_pulse, o_overall_clear;
    logic o_led_red, o_led_green, o_led_batt, o_mod_fault_led;
    // Bookkeeping
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int clr_cnt = 0; // Clearing pulses seen
    int ovr_cnt = 0; // Overall reset pulses seen
    logic [7:0] d;
    always #20 i_clk_sys = ~i_clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    cms_top #(.BATT_FLASH_CYC(8)) DUT (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
        .i_pwr_on(pwr), .i_sel_run(sel), .i_batt_present(batt), .i_act_supply(act),
        .i_malfunction(malf), .i_param_done(pdone), .i_routine_done(rdone),
        .i_prog_loaded(i_prog_loaded), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .o_prog_exec(o_prog_exec),
        .o_retain_hold(o_retain_hold), .o_timer_run(o_timer_run),
        .o_counter_en(o_counter_en), .o_scan_mon_en(o_scan_mon_en),
        .o_timed_irq_en(o_timed_irq_en), .o_onboard_out_en(o_onboard_out_en),
        .o_ext_io_en(o_ext_io_en), .o_periph_ops_en(o_periph_ops_en),
        .o_param_eval(o_param_eval), .o_routine_run(o_routine_run),
        .o_routine_sel(o_routine_sel), .o_clear_pulse(o_clear_pulse),
        .o_overall_clear(o_overall_clear), .o_led_red(o_led_red),
        .o_led_green(o_led_green), .o_led_batt(o_led_batt),
        .o_mod_fault_led(o_mod_fault_led));
    cms_far u_far (.i_clk(i_clk_sys), .i_param_eval(o_param_eval),
        .i_routine_run(o_routine_run), .o_pwr_on(pwr), .o_sel_run(sel), .o_batt(batt),
        .o_act(act), .o_malf(malf), .o_param_done(pdone), .o_routine_done(rdone));
    ////////////////////////////////////////////////////////////////////////////
    // Pulse counters read the pre-edge value, so each pulse counts once
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (o_clear_pulse === 1'b1)
            clr_cnt++;
        if (o_overall_clear === 1'b1)
            ovr_cnt++;
        // Hang guard, far above the expected run length
        if (cyc == 30000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    // Gating and lamp outputs as one vector
    function automatic logic [13:0] gates();
        return {o_prog_exec, o_retain_hold, o_timer_run, o_counter_en, o_scan_mon_en,
            o_timed_irq_en, o_onboard_out_en, o_ext_io_en, o_periph_ops_en,
            o_param_eval, o_routine_run, o_led_red, o_led_green, o_mod_fault_led};
    endfunction
    // Expected gating per mode
    function automatic logic [13:0] gate_exp(input cms_state_t s);
        case (s)
            S_RUN: return 14'h2FC2;
            S_STOP: return 14'h1005;
            S_PARAM: return 14'h00B5;
            S_ROUTINE: return 14'h00AD;
            default: return 14'h1000;
        endcase
    endfunction
    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    // Read; data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask
    // Poll the mode code under a bounded count
    task automatic wait_state(input cms_state_t s);
        int n;
        n = 0;
        do
        begin
            rd(ADDR_STATUS, d);
            n++;
        end while (d[2:0] !== 3'(s) && n < 200);
        `CHK(d[2:0], 3'(s))
    endtask
    // Verdict and end of run
    task automatic wrap_up();
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(93));
        // Idle bus carries random address and data; no strobe, so nothing lands
        {i_rstn, i_prog_loaded, i_wr, i_rd} <= 4'h0;
        i_addr <= 4'($urandom);
        i_wdata <= 8'($urandom);
        repeat (12) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        wait_state(S_STOP);
        repeat (20) @(posedge i_clk_sys);
        `CHK(gates(), gate_exp(S_STOP))
        `CHK(o_led_batt, 1'b0)
        rd(4'(3 + $urandom % 13), d);
        `CHK(d, 8'h00)
        wr(ADDR_STATUS, 8'hFF);
        wr(ADDR_CTRL, 8'h01);
        repeat (10) @(posedge i_clk_sys);
        rd(ADDR_STATUS, d);
        `CHK({d[ST_EMPTY_BIT], d[2:0]}, {1'b1, 3'(S_STOP)})
        u_far.drive(5'h14);
        repeat (6) @(posedge i_clk_sys);
        `CHK(o_mod_fault_led, 1'b1)
        // Selector start-up through the restart steps
        u_far.lat = 10 + $urandom % 10;
        u_far.drive(5'h1E);
        wait_state(S_PARAM);
        `CHK(gates(), gate_exp(S_PARAM))
        `CHK(clr_cnt, 1)
        wait_state(S_ROUTINE);
        `CHK({o_routine_sel, gates()}, {1'b1, gate_exp(S_ROUTINE)})
        wait_state(S_RUN);
        rd(ADDR_STATUS, d);
        `CHK(d[ST_EMPTY_BIT], 1'b1)
        repeat (5 + $urandom % 30) @(posedge i_clk_sys);
        `CHK(gates(), gate_exp(S_RUN))
        // Malfunction forces a held stop
        u_far.drive(5'h1F);
        wait_state(S_STOP);
        `CHK(gates(), gate_exp(S_STOP))
        u_far.drive(5'h1E);
        rd(ADDR_FAULT, d);
        `CHK(d[FLT_BIT], 1'b1)
        repeat (6) @(posedge i_clk_sys);
        wr(ADDR_FAULT, 8'h01);
        rd(ADDR_FAULT, d);
        `CHK(d[FLT_BIT], 1'b0)
        rd(ADDR_STATUS, d);
        `CHK({d[ST_HOLD_BIT], d[2:0]}, {1'b1, 3'(S_STOP)})
        // Programmer run with selector at run; manual restart routine
        wr(ADDR_CTRL, 8'h01);
        wait_state(S_ROUTINE);
        `CHK(o_routine_sel, 1'b0)
        wait_state(S_RUN);
        `CHK(clr_cnt, 2)
        wr(ADDR_CTRL, 8'h02);
        wait_state(S_STOP);
        @(posedge i_clk_sys);
        i_prog_loaded <= 1'b1;
        @(posedge i_clk_sys);
        i_prog_loaded <= 1'b0;
        rd(ADDR_STATUS, d);
        `CHK(d[ST_EMPTY_BIT], 1'b0)
        // Three selector cycles with random executor delay
        repeat (3)
        begin
            u_far.lat = $urandom_range(20, 10);
            u_far.drive(5'h16);
            wait_state(S_STOP);
            u_far.drive(5'h1E);
            wait_state(S_RUN);
        end
        `CHK(clr_cnt, 5)
        // Power switch off, then on again stopped
        u_far.drive(5'h0E);
        wait_state(S_OFF);
        `CHK({o_led_batt, gates()}, {1'b0, gate_exp(S_OFF)})
        u_far.drive(5'h16);
        wait_state(S_STOP);
        // Battery lamp still in its power-up flash window here
        `CHK(o_led_batt, 1'b1)
        // Overall reset by hand, then battery back in
        u_far.clear_by_hand();
        wait_state(S_STOP);
        `CHK(ovr_cnt, 1)
        rd(ADDR_STATUS, d);
        `CHK({d[ST_EMPTY_BIT], o_led_batt}, 2'h3)
        u_far.drive(5'h16);
        repeat (20) @(posedge i_clk_sys);
        `CHK(o_led_batt, 1'b0)
        wrap_up();
    end
endmodule
